// File: src/txfd_pkg.sv
package txfd_pkg;

    // ****************************************************************
    // Register map (word index on the plain register port)
    // ****************************************************************
    localparam logic [3:0] ADDR_CTRL1 = 4'h1;
    localparam logic [3:0] ADDR_CTRL4 = 4'h4;
    localparam logic [3:0] ADDR_CTRL5 = 4'h5;
    localparam logic [3:0] ADDR_CTRL6 = 4'h6;
    localparam logic [3:0] ADDR_CTRL7 = 4'h7;
    localparam logic [3:0] ADDR_TXBUF = 4'h8;
    localparam logic [3:0] ADDR_RXBUF = 4'h9;
    localparam logic [3:0] ADDR_STATUS = 4'ha;
    localparam logic [3:0] ADDR_IRQDEL = 4'hb;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int OPM_LSB = 0;
    localparam int IRQLV_LSB = 3;
    localparam int PATTERN_BIT = 5;
    localparam int TRANSP_BIT = 6;
    localparam int ASK_BIT = 0;
    localparam int THR_LSB = 8;
    localparam int RXCNT_LSB = 8;
    localparam int ST_LOCK_BIT = 15;
    localparam int ST_IRQ_BIT = 14;
    localparam int ST_ACT_BIT = 13;

    localparam logic [2:0] OPM_TX = 3'h1;
    localparam logic [2:0] OPM_FD_MASTER = 3'h5;
    localparam logic [2:0] OPM_FD_SLAVE = 3'h7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ****************************************************************
    // Buffer and bit timing
    // ****************************************************************
    localparam int BUF_DEPTH = 16;
    localparam logic [4:0] BUF_FULL = 5'h10;
    localparam logic [3:0] BIT_LAST = 4'hf;
    localparam logic [3:0] BIT_HALF = 4'h8;
    localparam logic [3:0] BIT_SAMPLE = 4'hc;
    localparam logic [3:0] SNAP_LO = 4'h6;
    localparam logic [3:0] SNAP_HI = 4'ha;
    localparam logic [1:0] SLAVE_SYNC_BYTES = 2'h3;
    localparam logic [1:0] MASTER_ZERO_BYTES = 2'h2;

    // Times in tenths of a data_clock_period, counts in whole periods
    localparam int T_STARTUP_FD_X10 = 7985;
    localparam int T_SIG_SETTLE_X10 = 5460;
    localparam int T_PA_DELAY_X10 = 1680;
    localparam logic [9:0] STARTUP_FD_TICKS = 10'((T_STARTUP_FD_X10 + 9) / 10);
    localparam logic [9:0] SIG_SETTLE_TICKS = 10'((T_SIG_SETTLE_X10 + 9) / 10);
    localparam logic [9:0] PA_DELAY_TICKS = 10'(T_PA_DELAY_X10 / 10);

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_START = 8'h02,
        ST_TX = 8'h04,
        ST_SETTLE = 8'h08,
        ST_ARM = 8'h10,
        ST_SEND = 8'h20,
        ST_TAIL = 8'h40,
        ST_DONE = 8'h80
    } txfd_state_e;

endpackage : txfd_pkg

// File: src/txfd_sequencer.sv
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
// Function
// - Mode field 001 selects transmit operation
// - Start-up with PLL on until lock
// - Load in start-up/transmit; auto-send MSB first
// - Threshold from low five command bits
// - Pending counter up on load, down on send
// - Interrupt when counter reaches selected level
// - Config writes while active flush buffer, counter
// - Pattern mode sends raw NRZ bits
// - Transparent mode modulates from input pin
// - ASK/FSK select; Manchester 1 rises, 0 falls
// - Mode 101 master, 111 slave full duplex
// - Full duplex starts in start-up, accepts loads
// - Full duplex PLL locked after 798.5 periods
// - Master sends once locked and threshold met
// - Slave settles 546, checks, then sends
// - Align bit timing during sync pattern
// - Empty buffer: interrupt, amplifier off 168 later
// - Store received XOR transmitted data bits
// - Buffer read shows received byte count
// - Interrupt high on event, low when cleared
module txfd_sequencer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [15:0] reg_rdata,
    input wire logic data_clk,
    input wire logic pll_lock,
    input wire logic rx_data,
    input wire logic serial_in_transparent_tx,
    input wire logic bit_check_ok,
    input wire logic start_bit_seen,
    output logic pll_en,
    output logic pa_en,
    output logic rx_proc_en,
    output logic amplitude_not_freq_sel,
    output logic mod_out,
    output logic irq,
    output logic [7:0] cfg_ctrl5,
    output logic [7:0] cfg_ctrl6,
    output logic [7:0] cfg_ctrl7
);

    // ****************************************************************
    // Input synchronisers and data clock edge detection
    // ****************************************************************
    logic [1:0] dclk_sy;
    logic dclk_d;
    logic [1:0] lock_sy;
    logic [1:0] rx_sy;
    logic rx_d;
    logic [1:0] tp_sy;
    logic [1:0] chk_sy;
    logic [1:0] stb_sy;

    // Two flops on every input but the register port and reset, a third on clock and data for edges
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dclk_sy <= 2'h0;
            dclk_d <= 1'b0;
            lock_sy <= 2'h0;
            rx_sy <= 2'h0;
            rx_d <= 1'b0;
            tp_sy <= 2'h0;
            chk_sy <= 2'h0;
            stb_sy <= 2'h0;
        end else begin
            dclk_sy <= {dclk_sy[0], data_clk};
            dclk_d <= dclk_sy[1];
            lock_sy <= {lock_sy[0], pll_lock};
            rx_sy <= {rx_sy[0], rx_data};
            rx_d <= rx_sy[1];
            tp_sy <= {tp_sy[0], serial_in_transparent_tx};
            chk_sy <= {chk_sy[0], bit_check_ok};
            stb_sy <= {stb_sy[0], start_bit_seen};
        end
    end

    wire tick = dclk_sy[1] & ~dclk_d;
    wire locked = lock_sy[1];
    wire rx_bit = rx_sy[1];
    wire rx_edge = rx_sy[1] ^ rx_d;

    // ****************************************************************
    // Control registers and decode
    // ****************************************************************
    logic [7:0] ctrl1;
    logic [7:0] ctrl4;
    logic [4:0] thresh;
    txfd_pkg::txfd_state_e state;
    txfd_pkg::txfd_state_e next_state;

    wire [2:0] opm = ctrl1[txfd_pkg::OPM_LSB +: 3];
    wire [1:0] irq_lv = ctrl1[txfd_pkg::IRQLV_LSB +: 2];
    wire pattern = ctrl1[txfd_pkg::PATTERN_BIT];
    wire transp = ctrl1[txfd_pkg::TRANSP_BIT];
    wire is_tx = (opm == txfd_pkg::OPM_TX);
    wire is_master = (opm == txfd_pkg::OPM_FD_MASTER);
    wire is_slave = (opm == txfd_pkg::OPM_FD_SLAVE);
    wire is_fd = is_master | is_slave;

    wire wr_c1 = reg_we & (reg_addr == txfd_pkg::ADDR_CTRL1);
    wire wr_c4 = reg_we & (reg_addr == txfd_pkg::ADDR_CTRL4);
    wire wr_c5 = reg_we & (reg_addr == txfd_pkg::ADDR_CTRL5);
    wire wr_c6 = reg_we & (reg_addr == txfd_pkg::ADDR_CTRL6);
    wire wr_c7 = reg_we & (reg_addr == txfd_pkg::ADDR_CTRL7);
    wire wr_cfg = wr_c1 | wr_c4 | wr_c5 | wr_c6 | wr_c7;
    wire wr_buf = reg_we & (reg_addr == txfd_pkg::ADDR_TXBUF);
    wire wr_del = reg_we & (reg_addr == txfd_pkg::ADDR_IRQDEL);
    wire rd_rx = reg_re & (reg_addr == txfd_pkg::ADDR_RXBUF);
    wire flush = wr_cfg & (state != txfd_pkg::ST_IDLE);
    wire load_ok = (state == txfd_pkg::ST_START) | (state == txfd_pkg::ST_TX)
        | (state == txfd_pkg::ST_SETTLE) | (state == txfd_pkg::ST_ARM)
        | (state == txfd_pkg::ST_SEND);
    wire [4:0] thr_raw = reg_wdata[txfd_pkg::THR_LSB +: 5];
    wire [4:0] thr_new = (thr_raw > txfd_pkg::BUF_FULL) ? txfd_pkg::BUF_FULL : thr_raw;

    // Software-written configuration
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl1 <= txfd_pkg::CTRL_RESET;
            ctrl4 <= txfd_pkg::CTRL_RESET;
            cfg_ctrl5 <= txfd_pkg::CTRL_RESET;
            cfg_ctrl6 <= txfd_pkg::CTRL_RESET;
            cfg_ctrl7 <= txfd_pkg::CTRL_RESET;
            thresh <= 5'h00;
        end else begin
            if (wr_c1) ctrl1 <= reg_wdata[7:0];
            if (wr_c4) ctrl4 <= reg_wdata[7:0];
            if (wr_c5) cfg_ctrl5 <= reg_wdata[7:0];
            if (wr_c6) cfg_ctrl6 <= reg_wdata[7:0];
            if (wr_c7) cfg_ctrl7 <= reg_wdata[7:0];
            if (wr_buf) thresh <= thr_new;
        end
    end

    assign amplitude_not_freq_sel = ctrl4[txfd_pkg::ASK_BIT];

    // ****************************************************************
    // Transmit buffer and pending-byte counter
    // ****************************************************************
    logic [7:0] tx_mem [txfd_pkg::BUF_DEPTH];
    logic [3:0] tx_wp;
    logic [3:0] tx_rp;
    logic [4:0] tx_cnt;
    logic load;

    wire push = wr_buf & load_ok & ~transp & (tx_cnt != txfd_pkg::BUF_FULL);
    wire [4:0] next_tx_cnt = tx_cnt + {4'h0, push} - {4'h0, load};

    // Writes enter at the tail, the shifter takes from the head
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            tx_cnt <= 5'h00;
        end else if (flush) begin
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            tx_cnt <= 5'h00;
        end else begin
            if (push) tx_wp <= tx_wp + 4'h1;
            if (load) tx_rp <= tx_rp + 4'h1;
            tx_cnt <= next_tx_cnt;
        end
    end

    // Buffer storage has no reset
    always_ff @(posedge mclk) begin
        if (push) tx_mem[tx_wp] <= reg_wdata[7:0];
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    logic [9:0] timer;
    logic active;
    logic was_active;

    wire have_n = (tx_cnt >= thresh) & (tx_cnt != 5'h00);
    wire slave_go = chk_sy[1] & stb_sy[1] & have_n;
    wire arm_go = is_master ? have_n : slave_go;
    wire fd_empty = (state == txfd_pkg::ST_SEND) & was_active & ~active;
    wire start_tx = ((state == txfd_pkg::ST_TX) & ~transp & ~active & have_n)
        | ((state == txfd_pkg::ST_ARM) & arm_go);

    // Next state of the mode sequencer
    always_comb begin
        next_state = state;
        case (state)
            txfd_pkg::ST_IDLE: next_state = txfd_pkg::ST_IDLE;
            txfd_pkg::ST_START: begin
                if (is_tx & locked) begin
                    next_state = txfd_pkg::ST_TX;
                end else if (is_fd & locked & (timer >= txfd_pkg::STARTUP_FD_TICKS)) begin
                    next_state = is_slave ? txfd_pkg::ST_SETTLE : txfd_pkg::ST_ARM;
                end
            end
            txfd_pkg::ST_TX: next_state = txfd_pkg::ST_TX;
            txfd_pkg::ST_SETTLE: begin
                if (timer >= txfd_pkg::SIG_SETTLE_TICKS) next_state = txfd_pkg::ST_ARM;
            end
            txfd_pkg::ST_ARM: begin
                if (arm_go) next_state = txfd_pkg::ST_SEND;
            end
            txfd_pkg::ST_SEND: begin
                if (fd_empty) next_state = txfd_pkg::ST_TAIL;
            end
            txfd_pkg::ST_TAIL: begin
                if (timer >= txfd_pkg::PA_DELAY_TICKS) next_state = txfd_pkg::ST_DONE;
            end
            txfd_pkg::ST_DONE: next_state = txfd_pkg::ST_DONE;
            default: next_state = txfd_pkg::ST_IDLE;
        endcase
        if (wr_c1) begin
            next_state = txfd_pkg::ST_IDLE;
            if ((reg_wdata[2:0] == txfd_pkg::OPM_TX) | reg_wdata[2] & reg_wdata[0]) begin
                next_state = txfd_pkg::ST_START;
            end
        end
    end

    // State register and data clock period timer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= txfd_pkg::ST_IDLE;
            timer <= 10'h000;
        end else begin
            state <= next_state;
            if (next_state != state) timer <= 10'h000;
            else if (tick & (timer != 10'h3ff)) timer <= timer + 10'h001;
        end
    end

    // Analog enables decoded from state
    assign pll_en = (state != txfd_pkg::ST_IDLE) & (state != txfd_pkg::ST_DONE);
    assign pa_en = (state == txfd_pkg::ST_TX) | (state == txfd_pkg::ST_SEND)
        | (state == txfd_pkg::ST_TAIL)
        | (is_slave & ((state == txfd_pkg::ST_SETTLE) | (state == txfd_pkg::ST_ARM)));
    assign rx_proc_en = (state == txfd_pkg::ST_SEND) | (state == txfd_pkg::ST_TAIL)
        | (is_slave & ((state == txfd_pkg::ST_SETTLE) | (state == txfd_pkg::ST_ARM)));

    // ****************************************************************
    // Bit shifter and framing
    // ****************************************************************
    logic [7:0] shreg;
    logic [2:0] bit_idx;
    logic [3:0] ph;
    logic [1:0] frame_cnt;
    logic in_data;
    logic cur_data;

    wire byte_end = active & tick & (ph == txfd_pkg::BIT_LAST) & (bit_idx == 3'h0);
    wire [7:0] head = tx_mem[tx_rp];
    wire head_is_data = is_master ? (frame_cnt == txfd_pkg::MASTER_ZERO_BYTES)
        : (frame_cnt == txfd_pkg::SLAVE_SYNC_BYTES);
    wire snap = (state == txfd_pkg::ST_SEND) & ~cur_data & rx_edge
        & (ph >= txfd_pkg::SNAP_LO) & (ph <= txfd_pkg::SNAP_HI);
    assign load = start_tx | (byte_end & (tx_cnt != 5'h00) & ~flush);

    // Shift out MSB first, one bit per sixteen data clock periods
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shreg <= 8'h00;
            bit_idx <= 3'h0;
            ph <= 4'h0;
            active <= 1'b0;
            was_active <= 1'b0;
        end else begin
            was_active <= active;
            if (flush) begin
                active <= 1'b0;
            end else if (load) begin
                shreg <= head;
                bit_idx <= 3'h7;
                ph <= 4'h0;
                active <= 1'b1;
            end else if (byte_end) begin
                active <= 1'b0;
            end else if (snap) begin
                ph <= txfd_pkg::BIT_HALF;
            end else if (active & tick) begin
                ph <= ph + 4'h1;
                if (ph == txfd_pkg::BIT_LAST) begin
                    shreg <= {shreg[6:0], 1'b0};
                    bit_idx <= bit_idx - 3'h1;
                end
            end
        end
    end

    // Track sync bytes so the data block is known
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_cnt <= 2'h0;
            in_data <= 1'b0;
            cur_data <= 1'b0;
        end else if (flush | (state == txfd_pkg::ST_START)) begin
            frame_cnt <= 2'h0;
            in_data <= 1'b0;
            cur_data <= 1'b0;
        end else if (load) begin
            cur_data <= in_data | head_is_data;
            if (head_is_data) begin
                in_data <= 1'b1;
            end else if (is_master) begin
                frame_cnt <= (head == 8'h00) ? frame_cnt + 2'h1 : 2'h0;
            end else begin
                frame_cnt <= frame_cnt + 2'h1;
            end
        end
    end

    // ****************************************************************
    // Modulator
    // ****************************************************************
    wire cur_bit = shreg[7];
    wire first_half = (ph < txfd_pkg::BIT_HALF);
    wire manch = first_half ? ~cur_bit : cur_bit;
    wire buf_level = pattern ? cur_bit : manch;
    wire next_mod = ((state == txfd_pkg::ST_TX) & transp) ? tp_sy[1]
        : (active & buf_level);

    // Registered level towards the RF modulator
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) mod_out <= 1'b0;
        else mod_out <= next_mod;
    end

    // ****************************************************************
    // Receive buffer: received XOR transmitted
    // ****************************************************************
    logic [7:0] rx_mem [txfd_pkg::BUF_DEPTH];
    logic [3:0] rx_wp;
    logic [3:0] rx_rp;
    logic [4:0] rx_cnt;
    logic [6:0] rx_sh;
    logic [2:0] rx_bits;

    wire rx_take = (state == txfd_pkg::ST_SEND) & active & cur_data & tick
        & (ph == txfd_pkg::BIT_SAMPLE);
    wire rx_xbit = rx_bit ^ cur_bit;
    wire rx_byte = rx_take & (rx_bits == 3'h7);
    wire rx_over = rx_byte & (rx_cnt == txfd_pkg::BUF_FULL);
    wire pop = rd_rx & (rx_cnt != 5'h00);
    wire [4:0] next_rx_cnt = rx_cnt + {4'h0, rx_byte & ~rx_over} - {4'h0, pop & ~rx_byte};

    // Assemble bytes, overwrite oldest on overflow
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_cnt <= 5'h00;
            rx_sh <= 7'h00;
            rx_bits <= 3'h0;
        end else if (flush | (state == txfd_pkg::ST_START)) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_cnt <= 5'h00;
            rx_bits <= 3'h0;
        end else begin
            if (rx_take) begin
                rx_sh <= {rx_sh[5:0], rx_xbit};
                rx_bits <= rx_bits + 3'h1;
            end
            if (rx_byte) rx_wp <= rx_wp + 4'h1;
            if (rx_over | (pop & ~rx_byte)) rx_rp <= rx_rp + 4'h1;
            rx_cnt <= rx_byte & pop ? rx_cnt : next_rx_cnt;
        end
    end

    // Receive storage has no reset
    always_ff @(posedge mclk) begin
        if (rx_byte) rx_mem[rx_wp] <= {rx_sh, rx_xbit};
    end

    // ****************************************************************
    // Interrupt
    // ****************************************************************
    function automatic logic [4:0] irq_target(input logic [1:0] sel);
        case (sel)
            2'h0: irq_target = 5'h01;
            2'h1: irq_target = 5'h02;
            2'h2: irq_target = 5'h04;
            default: irq_target = 5'h0c;
        endcase
    endfunction : irq_target

    wire reach = push & ~load & (next_tx_cnt == irq_target(irq_lv));
    wire irq_set = reach | fd_empty;
    wire irq_clr = wr_buf | wr_cfg | wr_del | rd_rx;

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) irq <= 1'b0;
        else irq <= irq_set | (irq & ~irq_clr);
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    wire [15:0] rd_status = {locked, irq, active, 8'h00, tx_cnt};
    wire [15:0] rd_rxbuf = {3'h0, rx_cnt, rx_mem[rx_rp]};
    wire [15:0] rd_mux = (reg_addr == txfd_pkg::ADDR_STATUS) ? rd_status
        : (reg_addr == txfd_pkg::ADDR_RXBUF) ? rd_rxbuf
        : (reg_addr == txfd_pkg::ADDR_CTRL1) ? {8'h00, ctrl1}
        : (reg_addr == txfd_pkg::ADDR_CTRL4) ? {8'h00, ctrl4}
        : 16'h0000;

    // Read data valid the cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) reg_rdata <= 16'h0000;
        else if (reg_re) reg_rdata <= rd_mux;
        else reg_rdata <= 16'h0000;
    end

endmodule : txfd_sequencer

// File: verification/txfd_sequencer_sva.sv
`timescale 1ns/1ns
// ****
// Port checker
// ****
module txfd_sequencer_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [15:0] reg_rdata,
    input wire logic pll_lock,
    input wire logic pll_en,
    input wire logic pa_en,
    input wire logic irq,
    input wire logic amplitude_not_freq_sel
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Write decodes
    wire logic wr1 = reg_we && reg_addr == txfd_pkg::ADDR_CTRL1;
    wire logic wr4 = reg_we && reg_addr == txfd_pkg::ADDR_CTRL4;
    wire logic wdel = reg_we && reg_addr == txfd_pkg::ADDR_IRQDEL;
    chk_read_slot: assert property (!$past(reg_re) |-> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    chk_tx_pll: assert property (wr1 && reg_wdata[2:0] == 3'h1 |=> pll_en)
        else $error("pll off after transmit select");
    chk_fd_pll: assert property (wr1 && reg_wdata[2] && reg_wdata[0] |=> pll_en)
        else $error("pll off after duplex select");
    chk_idle_off: assert property (wr1 && reg_wdata[2:0] == 3'h0 |=> !pll_en && !pa_en)
        else $error("idle select left radio on");
    chk_pa_lock: assert property ($rose(pa_en) |-> $past(pll_lock, 2))
        else $error("amplifier on without lock");
    chk_pa_pll: assert property (pa_en |-> pll_en)
        else $error("amplifier on with pll off");
    chk_ask_sel: assert property (wr4 |=> amplitude_not_freq_sel == $past(reg_wdata[0]))
        else $error("modulation select not taken");
    chk_irq_del: assert property (wdel |=> !irq)
        else $error("interrupt not deleted");
    chk_irq_flush: assert property (wr4 |=> !irq)
        else $error("interrupt kept over flush");
    // Main scenarios reached
    cover property ($rose(pa_en));
    cover property ($fell(irq));
    cover property (wr1 && reg_wdata[2:0] == 3'h5);
endmodule : txfd_sequencer_chk

bind txfd_sequencer txfd_sequencer_chk chk (.mclk, .rst, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .pll_lock, .pll_en, .pa_en, .irq, .amplitude_not_freq_sel);

// File: verification/txfd_radio_model.sv
`timescale 1ns/1ns
// ****
// Radio side model
// ****
module txfd_radio_model (
    input wire logic mclk,
    input wire logic pll_en,
    input wire logic rx_proc_en,
    output logic data_clk,
    output logic pll_lock,
    output logic rx_data,
    output logic bit_check_ok,
    output logic start_bit_seen
);
    int lock_cnt;
    // Free data clock, own phase
    initial begin
        {pll_lock, rx_data, bit_check_ok, start_bit_seen} = 4'h0;
        lock_cnt = 0;
        data_clk = 1'b0;
        #13;
        forever #40 data_clk = ~data_clk;
    end
    // Lock some cycles after enable, silent peer
    always @(posedge mclk) begin
        lock_cnt <= pll_en ? lock_cnt + 1 : 0;
        pll_lock <= pll_en && lock_cnt > 40;
        rx_data <= 1'b0;
        bit_check_ok <= rx_proc_en;
        start_bit_seen <= rx_proc_en;
    end
endmodule : txfd_radio_model

// File: verification/txfd_sequencer_tb.sv
`timescale 1ns/1ns
// ****
// Bench
// ****
module txfd_sequencer_tb;
    logic mclk, rst, reg_we, reg_re, serial_in_transparent_tx, rd_d;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, m;
    logic data_clk, pll_lock, rx_data, bit_check_ok, start_bit_seen;
    logic pll_en, pa_en, rx_proc_en, amplitude_not_freq_sel, mod_out, irq;
    logic [7:0] cfg_ctrl5, cfg_ctrl6, cfg_ctrl7;
    logic [15:0] exp_q[$], msk_q[$];
    logic [31:0] seed;
    int n_fail, comparisons, cyc, t0;
    txfd_sequencer DUT (.*);
    txfd_radio_model radio (.*);
    // Clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic summarize;
        if (n_fail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge mclk);
        reg_we <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] k);
        exp_q.push_back(e & k);
        msk_q.push_back(k);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        @(posedge mclk);
    endtask : rd
    task automatic frame(input logic [15:0] c1, input int d0, d1, d2, input logic [2:0] lv);
        wr(txfd_pkg::ADDR_CTRL1, c1);
        for (int i = 0; i < 300 && pa_en !== 1'b1; i++) @(posedge mclk);
        wr(txfd_pkg::ADDR_TXBUF, 16'h0180);
        for (int i = 0; i < 3000 && mod_out !== 1'b1; i++) @(posedge mclk);
        repeat (d0) @(posedge mclk);
        chk("mod_out", mod_out, lv[2]);
        repeat (d1) @(posedge mclk);
        chk("mod_out", mod_out, lv[1]);
        repeat (d2) @(posedge mclk);
        chk("mod_out", mod_out, lv[0]);
    endtask : frame
    // Read data scoreboard
    always @(posedge mclk) begin
        if (rd_d) begin
            m = msk_q.pop_front();
            chk("reg_rdata", reg_rdata & m, exp_q.pop_front());
        end
        rd_d <= reg_re;
    end
    // Hang limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        {rst, reg_we, reg_re, serial_in_transparent_tx, rd_d} = 5'h10;
        {reg_addr, reg_wdata, cyc, n_fail, comparisons} = '0;
        seed = 32'h39f9fe38;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(txfd_pkg::ADDR_STATUS, 16'h0000, 16'hffff);
        rd(4'hf, 16'h0000, 16'hffff);
        wr(txfd_pkg::ADDR_CTRL4, 16'h0001);
        chk("amplitude_not_freq_sel", amplitude_not_freq_sel, 16'h0001);
        wr(txfd_pkg::ADDR_CTRL1, 16'h0001);
        chk("pll_en", pll_en, 16'h0001);
        chk("pa_en", pa_en, 16'h0000);
        seed = xs(seed);
        wr(txfd_pkg::ADDR_TXBUF, {8'h03, seed[7:0]});
        rd(txfd_pkg::ADDR_STATUS, 16'h4001, 16'h401f);
        wr(txfd_pkg::ADDR_IRQDEL, 16'h0000);
        wr(txfd_pkg::ADDR_TXBUF, {8'h03, seed[15:8]});
        rd(txfd_pkg::ADDR_STATUS, 16'h0002, 16'h401f);
        wr(txfd_pkg::ADDR_CTRL5, {8'h00, seed[23:16]});
        chk("cfg_ctrl5", cfg_ctrl5, {8'h00, seed[23:16]});
        rd(txfd_pkg::ADDR_STATUS, 16'h0000, 16'h401f);
        frame(16'h0001, 64, 96, 64, 3'b101);
        frame(16'h0021, 64, 128, 608, 3'b100);
        wr(txfd_pkg::ADDR_CTRL1, 16'h0041);
        repeat (8) begin
            seed = xs(seed);
            serial_in_transparent_tx <= seed[0];
            repeat (8) @(posedge mclk);
            chk("mod_out", mod_out, serial_in_transparent_tx);
        end
        // Duplex master: preburst, start bit, sync, one data byte
        seed = xs(seed);
        wr(txfd_pkg::ADDR_CTRL6, 16'h0001);
        chk("cfg_ctrl6", cfg_ctrl6, 16'h0001);
        wr(txfd_pkg::ADDR_CTRL7, {8'h00, seed[15:8]});
        chk("cfg_ctrl7", cfg_ctrl7, {8'h00, seed[15:8]});
        wr(txfd_pkg::ADDR_CTRL1, 16'h0005);
        t0 = cyc;
        for (int i = 0; i < 9; i++)
            wr(txfd_pkg::ADDR_TXBUF, {8'h09, i < 4 ? 8'hff : i == 4 ? 8'hfe : i == 5 ?
                8'hff : i < 8 ? 8'h00 : seed[7:0]});
        while (cyc - t0 < 5600) @(posedge mclk);
        chk("pa_en", pa_en, 16'h0000);
        for (int i = 0; i < 1000 && pa_en !== 1'b1; i++) @(posedge mclk);
        chk("startup_time", 16'(cyc - t0 >= 6384 && cyc - t0 <= 6416), 16'h0001);
        chk("rx_proc_en", rx_proc_en, 16'h0001);
        for (int i = 0; i < 12000 && irq !== 1'b1; i++) @(posedge mclk);
        t0 = cyc;
        chk("pa_en", pa_en, 16'h0001);
        for (int i = 0; i < 2000 && pa_en !== 1'b0; i++) @(posedge mclk);
        chk("pa_delay", 16'(cyc - t0 >= 1330 && cyc - t0 <= 1356), 16'h0001);
        rd(txfd_pkg::ADDR_RXBUF, {8'h01, seed[7:0]}, 16'h1fff);
        wr(txfd_pkg::ADDR_CTRL1, 16'h0000);
        chk("pll_en", pll_en, 16'h0000);
        repeat (4) @(posedge mclk);
        // Duplex slave: sync pattern and one data byte
        seed = xs(seed);
        wr(txfd_pkg::ADDR_CTRL1, 16'h0007);
        t0 = cyc;
        for (int i = 0; i < 4; i++)
            wr(txfd_pkg::ADDR_TXBUF, {8'h04, i == 0 ? 8'h00 : i == 1 ? 8'h7f
                : i == 2 ? 8'hff : seed[7:0]});
        for (int i = 0; i < 7000 && pa_en !== 1'b1; i++) @(posedge mclk);
        chk("slave_pa", 16'(cyc - t0 >= 6384 && cyc - t0 <= 6416), 16'h0001);
        chk("rx_proc_en", rx_proc_en, 16'h0001);
        for (int i = 0; i < 12000 && irq !== 1'b1; i++) @(posedge mclk);
        rd(txfd_pkg::ADDR_RXBUF, {8'h01, seed[7:0]}, 16'h1fff);
        repeat (4) @(posedge mclk);
        summarize();
    end
endmodule : txfd_sequencer_tb
